//--- bench/bus_partner.sv
// two-wire bus partner: start, stop, bytes and clock stretches
// assumes pull-ups, so a let-go line reads high
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
    // clock
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start();
        sda <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(4);
    endtask
    task automatic stop();
        sda <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b1;
        hold(4);
    endtask
    // 400 ns slots; data moves a cycle after scl falls
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 9; i++) begin
            sda <= i < 8 ? b[7-i] : 1'b0;
            hold(3);
            scl <= 1'b1;
            hold(4);
            scl <= 1'b0;
            hold(1);
        end
    endtask
    // holds clock low, then lets go
    task automatic stretch(input int n);
        scl <= 1'b0;
        hold(n);
        scl <= 1'b1;
        hold(4);
    endtask
endmodule
`default_nettype wire

//--- bench/i2c_bus_timeout_monitor_test.sv
// self-checking bench for the bus timeout monitor
// assumes the partner model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
`include "i2c_tmo_map.svh"
module i2c_bus_timeout_monitor_test;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic microsecond_tick, millisecond_tick, master_start, addr_acked;
    logic boot_active, scl, sda, bus_abort, irq;
    logic [`TMO_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] div_ff = 4'h0;
    int errors, n_compared, seed;
    int n_abort;
    i2c_bus_timeout_monitor uut (.clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .microsecond_tick,
        .millisecond_tick, .master_start, .addr_acked, .boot_active,
        .scl_in(scl), .sda_in(sda), .bus_abort, .irq);
    bus_partner link (.clk, .scl, .sda);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // fast divider: a tick every 4 and every 16 cycles keeps runs short
    always @(posedge clk) begin
        div_ff <= div_ff + 4'h1;
        microsecond_tick <= div_ff[1:0] == 2'h3;
        millisecond_tick <= div_ff == 4'hf;
    end
    // abort pulses counted, so each expiry is seen exactly once
    always @(posedge clk) begin
        if (bus_abort === 1'b1) n_abort <= n_abort + 1;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [19:0] a,
            input logic [31:0] wd, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // waits as long as the slave asks; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never re-drives psel at once
        @(posedge clk);
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] wd);
        logic [31:0] q;
        apb(1'b1, a, wd, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    function automatic logic [31:0] ev(input int e);
        return 32'h1 << e;
    endfunction
    task automatic go(input logic ack);
        if (ack) addr_acked <= 1'b1;
        else master_start <= 1'b1;
        @(posedge clk);
        addr_acked <= 1'b0;
        master_start <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        idle(20000);
        errors++;
        print_verdict();
    end
    initial begin
        {rstn, psel, penable, pwrite, master_start, addr_acked} = 6'h0;
        boot_active = 1'b0;
        paddr = 20'h0;
        pwdata = 32'h0;
        seed = 32'h08b46f39;
        idle(4);
        rstn <= 1'b1;
        idle(3);
        rd_chk(`TMO_OFF_CLK_ARB, `TMO_RST_CLK_ARB);
        rd_chk(`TMO_OFF_BYTE_XACT, `TMO_RST_BYTE_XACT);
        rd_chk(20'h1d35c, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(`TMO_OFF_BYTE_XACT, d);
            rd_chk(`TMO_OFF_BYTE_XACT, d);
        end
        $display("register test done");
        wr(`TMO_OFF_MASK, 32'hf);
        wr(`TMO_OFF_BYTE_XACT, 32'h0);
        wr(`TMO_OFF_CLK_ARB, 32'h0002_0000);
        link.stretch(6);
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        link.stretch(40);
        chk({31'h0, irq}, 32'h1);
        chk(n_abort, 32'h1);
        rd_chk(`TMO_OFF_STATUS, ev(`TMO_EV_CLK_LOW));
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`TMO_OFF_CLK_ARB, 32'h0);
        link.stretch(60);
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        $display("clock low test done");
        wr(`TMO_OFF_CLK_ARB, 32'h0000_0002);
        go(1'b0);
        idle(10);
        go(1'b1);
        idle(80);
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        go(1'b0);
        idle(80);
        rd_chk(`TMO_OFF_STATUS, ev(`TMO_EV_ARB));
        boot_active <= 1'b1;
        go(1'b0);
        wr(`TMO_OFF_BYTE_XACT, 32'h0001_0001);
        link.start();
        idle(100);
        link.stop();
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        chk(n_abort, 32'h2);
        go(1'b1);
        boot_active <= 1'b0;
        $display("arbitration and boot test done");
        wr(`TMO_OFF_CLK_ARB, 32'h0);
        wr(`TMO_OFF_BYTE_XACT, 32'h0020_0000);
        link.start();
        d = $random(seed);
        link.send(d[7:0]);
        d = $random(seed);
        link.send(d[7:0]);
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        idle(200);
        rd_chk(`TMO_OFF_STATUS, ev(`TMO_EV_BYTE));
        link.stop();
        wr(`TMO_OFF_BYTE_XACT, 32'h0000_0002);
        link.start();
        idle(100);
        rd_chk(`TMO_OFF_STATUS, ev(`TMO_EV_XACT));
        link.stop();
        idle(100);
        rd_chk(`TMO_OFF_STATUS, 32'h0);
        chk(n_abort, 32'h4);
        $display("byte and transaction test done");
        print_verdict();
    end
endmodule
`default_nettype wire

//--- bench/tmo_monitor.sv
// port assertions for the bus timeout monitor
// assumes the map header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "i2c_tmo_map.svh"
module tmo_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TMO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // ticks and results
    input wire logic microsecond_tick,
    input wire logic millisecond_tick,
    input wire logic bus_abort,
    input wire logic irq
);
    logic [31:0] ca_ff, bx_ff;
    logic [3:0] mk_ff;
    logic hit;
    assign hit = paddr inside {`TMO_OFF_CLK_ARB, `TMO_OFF_BYTE_XACT,
        `TMO_OFF_STATUS, `TMO_OFF_MASK};
    // shadow copies, so readback is judged without the status side effect
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ca_ff <= `TMO_RST_CLK_ARB;
            bx_ff <= `TMO_RST_BYTE_XACT;
            mk_ff <= `TMO_RST_MASK;
        end else if (psel && penable && pwrite) begin
            if (paddr == `TMO_OFF_CLK_ARB) ca_ff <= pwdata;
            if (paddr == `TMO_OFF_BYTE_XACT) bx_ff <= pwdata;
            if (paddr == `TMO_OFF_MASK) mk_ff <= pwdata[3:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence acc; psel && penable; endsequence
    sequence rd(a); acc ##0 !pwrite && paddr == a; endsequence
    map_err_a: assert property (acc |-> pslverr == !hit)
        else $error("pslverr disagrees with address map");
    hole_zero_a: assert property (acc ##0 !pwrite && !hit |-> prdata == 0)
        else $error("unmapped read not zero");
    clk_arb_back_a: assert property (rd(`TMO_OFF_CLK_ARB) |-> prdata == ca_ff)
        else $error("limit register readback wrong");
    byte_back_a: assert property (rd(`TMO_OFF_BYTE_XACT) |-> prdata == bx_ff)
        else $error("byte register readback wrong");
    abort_tick_a: assert property (bus_abort |->
        $past(microsecond_tick, 2) || $past(millisecond_tick, 2))
        else $error("abort without a tick two cycles before");
    irq_follow_a: assert property (bus_abort && mk_ff == 4'hf |=> irq)
        else $error("irq missing after abort");
    irq_masked_a: assert property (mk_ff == 4'h0 [*4] |-> !irq)
        else $error("irq high while masked");
    limits_off_a: assert property ((ca_ff == 0 && bx_ff == 0) [*4] |-> !bus_abort)
        else $error("abort with every limit zero");
endmodule
bind i2c_bus_timeout_monitor tmo_checker u_chk (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .microsecond_tick, .millisecond_tick, .bus_abort, .irq);
`default_nettype wire

//--- common/i2c_tmo_map.svh
// offsets, field positions, reset values and event bit numbers of the monitor
// assumes byte addresses on a 20-bit apb window, 32-bit data
//
// How it works
// - time clock low from falling to rising edge; flag when over limit
// - clock-low limit is its count times the microsecond tick period
// - clock-low count of zero never raises a clock-low timeout
// - time master start to address ack; abort when over arbitration limit
// - arbitration limit counts millisecond ticks; zero disables it
// - arbitration timeout is suppressed while boot load runs
// - time start-to-ack, ack-to-ack, ack-to-stop; flag over byte limit
// - byte limit counts microsecond ticks; zero disables it
// - time start to stop; flag when over transaction limit
// - transaction limit counts millisecond ticks; zero disables it
// - byte and transaction limits reset to zero; ignored during boot
`ifndef I2C_TMO_MAP_SVH
`define I2C_TMO_MAP_SVH

`define TMO_ADDR_W 20
`define TMO_OFF_CLK_ARB 20'h1d354
`define TMO_OFF_BYTE_XACT 20'h1d358
`define TMO_OFF_STATUS 20'h1d360
`define TMO_OFF_MASK 20'h1d364

`define TMO_RST_CLK_ARB 32'h65bb0033
`define TMO_RST_BYTE_XACT 32'h00000000
`define TMO_RST_MASK 4'h0

// upper half holds the first field, lower half the second
`define TMO_HI_MSB 31
`define TMO_HI_LSB 16
`define TMO_LO_MSB 15
`define TMO_LO_LSB 0

`define TMO_EV_N 4
`define TMO_EV_CLK_LOW 0
`define TMO_EV_ARB 1
`define TMO_EV_BYTE 2
`define TMO_EV_XACT 3

`define TMO_BITS_PER_BYTE 4'h8

`endif

//--- common/i2c_tmo_pkg.sv
// types of the bus timeout monitor
// assumes the map header sits beside it
`include "i2c_tmo_map.svh"
package i2c_tmo_pkg;

    typedef enum logic {
        BUS_IDLE,
        BUS_BUSY
    } bus_state_t;

    typedef enum logic {
        ARB_IDLE,
        ARB_WAIT
    } arb_state_t;

    // pulses seen on the two-wire bus, plus clock level
    typedef struct packed {
        logic scl_low;
        logic scl_fall;
        logic start;
        logic stop;
        logic ack;
    } bus_event_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
        bus_state_t bus;
        logic [3:0] bitcnt;
        bus_event_t ev;
    } edge_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic fired;
        logic expired;
    } timer_state_t;

    typedef struct packed {
        logic [31:0] clk_arb;
        logic [31:0] byte_xact;
        logic [`TMO_EV_N-1:0] status;
        logic [`TMO_EV_N-1:0] mask;
        logic [31:0] prdata;
        logic irq;
        logic abort;
        arb_state_t arb;
        logic xact_run;
    } mon_state_t;

endpackage

//--- hdl/bus_edge_detect.sv
// samples the bus pins and finds clock edges, start, stop and ack bits
// assumes scl/sda arrive asynchronously from the pins
`timescale 1ns/10ps
`default_nettype none
`include "i2c_tmo_map.svh"
module bus_edge_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // events
    output i2c_tmo_pkg::bus_event_t ev
);

    i2c_tmo_pkg::edge_state_t st_ff;
    i2c_tmo_pkg::edge_state_t nxt_st;

    always_comb begin
        logic rise;
        rise = 1'b0;
        nxt_st = st_ff;
        nxt_st.scl_s1 = scl_in;
        nxt_st.scl_s2 = st_ff.scl_s1;
        nxt_st.sda_s1 = sda_in;
        nxt_st.sda_s2 = st_ff.sda_s1;
        nxt_st.scl_d = st_ff.scl_s2;
        nxt_st.sda_d = st_ff.sda_s2;
        rise = st_ff.scl_s2 & ~st_ff.scl_d;
        nxt_st.ev.scl_low = ~st_ff.scl_s2;
        nxt_st.ev.scl_fall = st_ff.scl_d & ~st_ff.scl_s2;
        // data moving while clock high marks start or stop
        nxt_st.ev.start = st_ff.scl_s2 & st_ff.scl_d & st_ff.sda_d
            & ~st_ff.sda_s2;
        nxt_st.ev.stop = st_ff.scl_s2 & st_ff.scl_d & ~st_ff.sda_d
            & st_ff.sda_s2;
        nxt_st.ev.ack = 1'b0;
        if (nxt_st.ev.start) begin
            nxt_st.bus = i2c_tmo_pkg::BUS_BUSY;
            nxt_st.bitcnt = 4'h0;
        end else if (nxt_st.ev.stop) begin
            nxt_st.bus = i2c_tmo_pkg::BUS_IDLE;
            nxt_st.bitcnt = 4'h0;
        end else if (rise && st_ff.bus == i2c_tmo_pkg::BUS_BUSY) begin
            // ninth clock of each byte carries ack or nack
            if (st_ff.bitcnt == `TMO_BITS_PER_BYTE) begin
                nxt_st.ev.ack = 1'b1;
                nxt_st.bitcnt = 4'h0;
            end else begin
                nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
                sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
                bus: i2c_tmo_pkg::BUS_IDLE, bitcnt: 4'h0, ev: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ev = st_ff.ev;

endmodule
`default_nettype wire

//--- hdl/i2c_bus_timeout_monitor.sv
// two-wire bus timeout monitor with apb registers and one interrupt
// assumes ticks, master start, address ack and boot flag from same clock
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_tmo_map.svh"
module i2c_bus_timeout_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TMO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // time-period divider
    input wire logic microsecond_tick,
    input wire logic millisecond_tick,
    // master sequencer
    input wire logic master_start,
    input wire logic addr_acked,
    input wire logic boot_active,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // results
    output logic bus_abort,
    output logic irq
);

    logic rst_meta_ff;
    logic rst_n_ff;
    i2c_tmo_pkg::bus_event_t ev;
    i2c_tmo_pkg::mon_state_t st_ff;
    i2c_tmo_pkg::mon_state_t nxt_st;
    logic [`TMO_EV_N-1:0] expired;
    logic [15:0] clock_low_limit;
    logic [15:0] arbitration_limit;
    logic [15:0] byte_limit;
    logic [15:0] transaction_limit;
    logic setup_rd;
    logic access;
    logic mapped;

    function automatic logic is_mapped(input logic [`TMO_ADDR_W-1:0] a);
        is_mapped = (a == `TMO_OFF_CLK_ARB) || (a == `TMO_OFF_BYTE_XACT)
            || (a == `TMO_OFF_STATUS) || (a == `TMO_OFF_MASK);
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    assign clock_low_limit = st_ff.clk_arb[`TMO_HI_MSB:`TMO_HI_LSB];
    assign arbitration_limit = st_ff.clk_arb[`TMO_LO_MSB:`TMO_LO_LSB];
    assign byte_limit = st_ff.byte_xact[`TMO_HI_MSB:`TMO_HI_LSB];
    assign transaction_limit = st_ff.byte_xact[`TMO_LO_MSB:`TMO_LO_LSB];

    bus_edge_detect u_edges (
        .clk(clk),
        .rst_n(rst_n_ff),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    // restarted by each falling clock edge, cleared while the clock is high
    tick_limit_timer u_clk_low (
        .clk(clk),
        .rst_n(rst_n_ff),
        .restart(ev.scl_fall),
        .run(ev.scl_low),
        .tick(microsecond_tick),
        .limit(clock_low_limit),
        .expired(expired[`TMO_EV_CLK_LOW])
    );

    tick_limit_timer u_arb (
        .clk(clk),
        .rst_n(rst_n_ff),
        .restart(master_start),
        .run(st_ff.arb == i2c_tmo_pkg::ARB_WAIT && !boot_active),
        .tick(millisecond_tick),
        .limit(arbitration_limit),
        .expired(expired[`TMO_EV_ARB])
    );

    // each start and each ack opens a new byte interval
    tick_limit_timer u_byte (
        .clk(clk),
        .rst_n(rst_n_ff),
        .restart(ev.start | ev.ack),
        .run(st_ff.xact_run && !boot_active),
        .tick(microsecond_tick),
        .limit(byte_limit),
        .expired(expired[`TMO_EV_BYTE])
    );

    // repeated start keeps the transaction running
    tick_limit_timer u_xact (
        .clk(clk),
        .rst_n(rst_n_ff),
        .restart(ev.start && !st_ff.xact_run),
        .run(st_ff.xact_run && !boot_active),
        .tick(millisecond_tick),
        .limit(transaction_limit),
        .expired(expired[`TMO_EV_XACT])
    );

    assign setup_rd = psel & ~penable & ~pwrite;
    assign access = psel & penable;
    assign mapped = is_mapped(paddr);

    always_comb begin
        logic [`TMO_EV_N-1:0] clr;
        clr = '0;
        nxt_st = st_ff;

        // arbitration window: master start until address ack or arbitration timeout
        unique case (st_ff.arb)
            i2c_tmo_pkg::ARB_IDLE: begin
                if (master_start) begin
                    nxt_st.arb = i2c_tmo_pkg::ARB_WAIT;
                end
            end
            i2c_tmo_pkg::ARB_WAIT: begin
                if (addr_acked || expired[`TMO_EV_ARB]) begin
                    nxt_st.arb = i2c_tmo_pkg::ARB_IDLE;
                end
            end
        endcase

        if (ev.start) begin
            nxt_st.xact_run = 1'b1;
        end else if (ev.stop) begin
            nxt_st.xact_run = 1'b0;
        end

        // read data captured in setup so the access phase sees a flop
        if (setup_rd) begin
            unique case (paddr)
                `TMO_OFF_CLK_ARB: nxt_st.prdata = st_ff.clk_arb;
                `TMO_OFF_BYTE_XACT: nxt_st.prdata = st_ff.byte_xact;
                `TMO_OFF_STATUS: begin
                    nxt_st.prdata = {28'h0000000, st_ff.status};
                end
                `TMO_OFF_MASK: nxt_st.prdata = {28'h0000000, st_ff.mask};
                default: nxt_st.prdata = 32'h00000000;
            endcase
        end

        if (access && pwrite) begin
            unique case (paddr)
                `TMO_OFF_CLK_ARB: nxt_st.clk_arb = pwdata;
                `TMO_OFF_BYTE_XACT: nxt_st.byte_xact = pwdata;
                `TMO_OFF_MASK: nxt_st.mask = pwdata[`TMO_EV_N-1:0];
                default: nxt_st.clk_arb = st_ff.clk_arb;
            endcase
        end

        // clear only what the read returned, so no event slips by unseen
        if (access && !pwrite && paddr == `TMO_OFF_STATUS) begin
            clr = st_ff.prdata[`TMO_EV_N-1:0];
        end
        // set wins over the read clear
        nxt_st.status = (st_ff.status & ~clr) | expired;
        nxt_st.abort = |expired;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            st_ff <= '{clk_arb: `TMO_RST_CLK_ARB,
                byte_xact: `TMO_RST_BYTE_XACT,
                status: '0, mask: `TMO_RST_MASK, prdata: 32'h00000000,
                irq: 1'b0, abort: 1'b0, arb: i2c_tmo_pkg::ARB_IDLE,
                xact_run: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = st_ff.prdata;
    assign bus_abort = st_ff.abort;
    assign irq = st_ff.irq;

endmodule
`default_nettype wire

//--- hdl/tick_limit_timer.sv
// counts divider ticks against a limit and pulses once when it is passed
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/10ps
`default_nettype none
module tick_limit_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic restart,
    input wire logic run,
    input wire logic tick,
    input wire logic [15:0] limit,
    // result
    output logic expired
);

    i2c_tmo_pkg::timer_state_t st_ff;
    i2c_tmo_pkg::timer_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.expired = 1'b0;
        if (restart || !run) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.fired = 1'b0;
        end else if (tick && !st_ff.fired && limit != 16'h0000) begin
            // expire on the tick after limit ticks: time exceeds limit
            if (st_ff.cnt == limit) begin
                nxt_st.expired = 1'b1;
                nxt_st.fired = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expired = st_ff.expired;

endmodule
`default_nettype wire
